// *** core/echp_defines.svh ***
/*
  constants for the card host port decode: address patterns, register fields, reset values, timing
  assumes inclusion by bare name from the host port module
*/
`ifndef ECHP_DEFINES_SVH
`define ECHP_DEFINES_SVH
// byte addresses of the card space registers
`define ECHP_PAGE_OFS 32'h0334_3000
`define ECHP_STAT_OFS 32'h0334_2000
`define ECHP_SRAM_OFS 32'h0334_1000
`define ECHP_PROM_OFS 32'h0334_0000
// decode patterns on local address bits 13:12
`define ECHP_SEL_PAGE 2'h3
`define ECHP_SEL_STAT 2'h2
`define ECHP_SEL_SRAM 2'h1
`define ECHP_SEL_PROM 2'h0
`define ECHP_SEL_CTRL 2'h3
`define ECHP_SEL_PORT 2'h2
// page register fields
`define ECHP_SRST_BIT 15
`define ECHP_DIR_BIT 14
`define ECHP_PAGE_HI 8
`define ECHP_PAGE_RST 16'h0000
// controller strobe timing
`define ECHP_CLK_NS 20
`define ECHP_STROBE_NS 60
`define ECHP_STROBE_CYC ((`ECHP_STROBE_NS + `ECHP_CLK_NS - 1) / `ECHP_CLK_NS)
// data port buffer
`define ECHP_FIFO_W 16
`define ECHP_FIFO_D 8
`endif

// *** core/echp_fifo.sv ***
/*
  data port buffer: parameterised fifo with valid and ready on both sides
  assumes one clock and a synchronous active high reset
*/
module echp_fifo #(
	parameter int W = 16,
	parameter int D = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];      // storage words
	logic [AW:0] wrPtr;         // write pointer with wrap bit
	logic [AW:0] rdPtr;         // read pointer with wrap bit
	wire logic full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
	wire logic empty = (wrPtr == rdPtr);
	wire logic push = inValid && !full;
	wire logic pop = outReady && !empty;
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr[AW-1:0]];
	// pointer update
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (push) wrPtr <= wrPtr + 1'b1;
			if (pop) rdPtr <= rdPtr + 1'b1;
		end
	end
	// word store
	always_ff @(posedge clk_sys) begin
		if (push) mem[wrPtr[AW-1:0]] <= inData;
	end
endmodule : echp_fifo

// *** core/echp_host_port.sv ***
/*
  host side decode and cycle access control of the network card
  assumes host cycles synchronous to clk_sys, held until hostReady
*/
`include "echp_defines.svh"
module echp_host_port
	import echp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic hostCycle,
	input wire logic hostModule,
	input wire logic hostWrite,
	input wire logic [13:2] hostAddr,
	input wire logic [15:0] hostWrData,
	output logic hostReady,
	output logic [15:0] hostRdData,
	output logic cardIrqN,
	output logic [18:0] promAddr,
	input wire logic [7:0] promData,
	output logic sramTestSel,
	output logic [3:0] ctrlRegSelect,
	output logic ctrlCsN,
	output logic ctrlRdN,
	output logic ctrlWrN,
	input wire logic [7:0] ctrlDataIn,
	output logic [7:0] ctrlDataOut,
	output logic ctrlDataOe,
	input wire logic ctrlBusReq,
	output logic ctrlBusAck,
	input wire logic ctrlIrq,
	output logic ctrlResetN,
	output logic portLatched,
	input wire logic dmaInValid,
	input wire logic [15:0] dmaInData,
	output logic dmaInReady,
	output logic dmaOutValid,
	output logic [15:0] dmaOutData,
	input wire logic dmaOutReady
);
	localparam logic [2:0] STROBE_LAST = 3'(`ECHP_STROBE_CYC - 1);

	echp_state_t state;        // cycle machine state
	echp_state_t next_state;   // its next value
	logic [15:0] page;         // page and port control register
	logic irqN;                // sampled controller interrupt, low active
	logic sideDone;            // card space cycle answered
	logic csActive;            // controller select held
	logic [2:0] slvCnt;        // strobe length counter
	logic [15:0] wrLatch;      // host write data held for the cycle

	// decode of the current host cycle
	wire logic [1:0] selBits = hostAddr[13:12];
	wire logic intRst = rst || !page[`ECHP_SRST_BIT];
	wire logic dirRead = page[`ECHP_DIR_BIT];
	wire logic modCtrl = hostModule && selBits == `ECHP_SEL_CTRL;
	wire logic modPort = hostModule && selBits == `ECHP_SEL_PORT;
	// cycles that never touch the internal bus
	wire logic sideHit = hostCycle && !sideDone && state == ST_IDLE
		&& (!hostModule || intRst || !(modCtrl || modPort));
	wire logic podHit = sideHit && !hostModule;
	wire logic pageWr = podHit && hostWrite && selBits == `ECHP_SEL_PAGE;
	wire logic statRd = podHit && !hostWrite && selBits == `ECHP_SEL_STAT;
	wire logic promRd = podHit && !hostWrite && selBits == `ECHP_SEL_PROM;
	wire logic sramHit = podHit && selBits == `ECHP_SEL_SRAM;
	// state groups
	wire logic stSlv = state == ST_SLV_RD || state == ST_SLV_WR;
	wire logic stMst = state == ST_MST_RD || state == ST_MST_WR;
	wire logic slvEnd = csActive && slvCnt == STROBE_LAST;

	// buffer hookup, direction from the page register
	logic fifoInValid;
	logic fifoInReady;
	logic [15:0] fifoInData;
	logic fifoOutValid;
	logic fifoOutReady;
	logic [15:0] fifoOutData;
	wire logic hostPush = state == ST_MST_WR && !dirRead;
	wire logic hostPop = state == ST_MST_RD && dirRead;
	assign fifoInValid = dirRead ? dmaInValid : hostPush;
	assign fifoInData = dirRead ? dmaInData : wrLatch;
	assign dmaInReady = dirRead && fifoInReady;
	assign fifoOutReady = dirRead ? hostPop : dmaOutReady;
	assign dmaOutValid = !dirRead && fifoOutValid;
	assign dmaOutData = fifoOutData;

	echp_fifo #(
		.W(`ECHP_FIFO_W),
		.D(`ECHP_FIFO_D)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(fifoInData),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady),
		.outData(fifoOutData)
	);

	// paged prom address: page field above word offset
	assign promAddr = {page[`ECHP_PAGE_HI:0], hostAddr[11:2]};
	assign hostReady = sideDone || state == ST_DONE;
	assign cardIrqN = irqN;
	assign ctrlResetN = page[`ECHP_SRST_BIT];
	assign ctrlCsN = !csActive;
	assign ctrlRdN = !(csActive && state == ST_SLV_RD);
	assign ctrlWrN = !(csActive && state == ST_SLV_WR);
	assign ctrlDataOe = csActive && state == ST_SLV_WR;
	assign ctrlDataOut = wrLatch[7:0];

	// page register, cleared only by power on reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			page <= `ECHP_PAGE_RST;
		end else if (pageWr) begin
			page <= hostWrData;
		end
	end

	// controller interrupt, passed on low active
	always_ff @(posedge clk_sys) begin
		if (rst) irqN <= 1'b1;
		else irqN <= !ctrlIrq;
	end

	// card space answer, next cycle, no arbitration
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sideDone <= 1'b0;
			sramTestSel <= 1'b0;
		end else begin
			sideDone <= sideHit || (sideDone && hostCycle);
			sramTestSel <= sramHit;
		end
	end

	// next state of the cycle machine
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				// wait for a module space cycle
				if (hostCycle && !intRst && modCtrl) begin
					next_state = hostWrite ? ST_SLV_WR : ST_SLV_RD;
				end else if (hostCycle && !intRst && modPort) begin
					next_state = hostWrite ? ST_MST_WR : ST_MST_RD;
				end
			end
			ST_SLV_RD, ST_SLV_WR: begin
				// hold until the strobe has run out
				if (slvEnd) next_state = ST_DONE;
			end
			ST_MST_RD: begin
				// wrong direction answers at once
				if (!dirRead || fifoOutValid) next_state = ST_DONE;
			end
			ST_MST_WR: begin
				if (dirRead || fifoInReady) next_state = ST_DONE;
			end
			ST_DONE: begin
				// host drops its cycle
				if (!hostCycle) next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// state register, idle on any internal reset
	always_ff @(posedge clk_sys) begin
		if (intRst) state <= ST_IDLE;
		else state <= next_state;
	end

	// bus ownership: controller keeps a running grant, new grant waits
	always_ff @(posedge clk_sys) begin
		if (intRst) ctrlBusAck <= 1'b0;
		else ctrlBusAck <= ctrlBusReq && (ctrlBusAck || !stSlv);
	end

	// controller select starts only once the bus is free
	always_ff @(posedge clk_sys) begin
		if (intRst) begin
			csActive <= 1'b0;
			slvCnt <= '0;
		end else begin
			csActive <= stSlv && !slvEnd && (csActive || (!ctrlBusAck && !ctrlBusReq));
			slvCnt <= csActive && !slvEnd ? slvCnt + 3'h1 : 3'h0;
		end
	end

	// register select and write data latched at cycle start
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrlRegSelect <= 4'h0;
			wrLatch <= 16'h0000;
		end else if (state == ST_IDLE && hostCycle) begin
			ctrlRegSelect <= hostAddr[5:2];
			wrLatch <= hostWrData;
		end
	end

	// transceiver mode: latched for port, transparent otherwise
	always_ff @(posedge clk_sys) begin
		if (rst) portLatched <= 1'b0;
		else portLatched <= next_state == ST_MST_RD || next_state == ST_MST_WR;
	end

	// read data; page read and status write return zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hostRdData <= 16'h0000;
		end else if (statRd) begin
			hostRdData <= {15'h0000, irqN};
		end else if (promRd) begin
			hostRdData <= {8'h00, promData};
		end else if (sideHit) begin
			hostRdData <= 16'h0000;
		end else if (state == ST_SLV_RD && slvEnd) begin
			hostRdData <= {8'h00, ctrlDataIn};
		end else if (state == ST_MST_RD && next_state == ST_DONE) begin
			hostRdData <= dirRead ? fifoOutData : 16'h0000;
		end
	end

	// power on reset gives page zero
	chk_page_reset: assert property (@(posedge clk_sys) rst |=> page == `ECHP_PAGE_RST)
		else $error("page register not cleared by reset");
	// page write lands whole
	chk_page_write: assert property (@(posedge clk_sys) disable iff (rst)
		pageWr |=> page == $past(hostWrData))
		else $error("page write lost");
	// page only moves on a page write, soft reset included
	chk_page_keep: assert property (@(posedge clk_sys) disable iff (rst)
		!pageWr |=> $stable(page))
		else $error("page changed without write");
	// status read shows interrupt low active in bit 0
	chk_status_bit: assert property (@(posedge clk_sys) disable iff (rst)
		statRd |=> hostRdData == {15'h0000, !$past(ctrlIrq, 2)})
		else $error("status read wrong");
	// card space answered on the next edge
	chk_side_fast: assert property (@(posedge clk_sys) disable iff (rst)
		podHit |=> hostReady)
		else $error("card space cycle stretched");
	// never select while the controller owns the bus
	chk_cs_guard: assert property (@(posedge clk_sys) disable iff (rst)
		!ctrlCsN |-> !ctrlBusAck)
		else $error("select during controller ownership");
	// strobe runs its full length
	chk_cs_width: assert property (@(posedge clk_sys) disable iff (intRst)
		$fell(ctrlCsN) |-> (!ctrlCsN) [*3] ##1 ctrlCsN)
		else $error("select width wrong");
	// register select stands during select
	chk_sel_stable: assert property (@(posedge clk_sys) disable iff (rst)
		!ctrlCsN && !$rose(!ctrlCsN) |-> $stable(ctrlRegSelect))
		else $error("register select moved");
	// host pop with a word present ends the cycle
	chk_port_pop: assert property (@(posedge clk_sys) disable iff (rst)
		hostPop && fifoOutValid |=> state == ST_DONE)
		else $error("port read not completed");
	// internal reset returns to idle
	chk_idle_reset: assert property (@(posedge clk_sys)
		intRst |=> state == ST_IDLE)
		else $error("cycle machine not idle");
endmodule : echp_host_port

// *** core/echp_pkg.sv ***
/*
  types shared by the card host port decode
  assumes echp_defines.svh is on the include path
*/
package echp_pkg;
	// host cycle state, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SLV_RD = 6'h02,
		ST_SLV_WR = 6'h04,
		ST_MST_RD = 6'h08,
		ST_MST_WR = 6'h10,
		ST_DONE = 6'h20
	} echp_state_t;
endpackage : echp_pkg

// *** dv/echp_ctrl_model.sv ***
/*
  model of the network controller register side facing the host port
  assumes strobes low active, one clock shared with the block
*/
module echp_ctrl_model (
	input wire logic clk_sys,
	input wire logic csN,
	input wire logic rdN,
	input wire logic wrN,
	input wire logic [3:0] regSel,
	input wire logic [7:0] wrData,
	input wire logic wrDataOe,
	output logic [7:0] rdData,
	input wire logic holdBus,
	output logic busReq,
	input wire logic busAck
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] regs [16]; // register file, ring pointers live here
	logic [7:0] junk; // toggling pattern while not selected
	initial begin
		foreach (regs[i]) regs[i] = 8'h00;
		junk = 8'h5a;
	end
	// store on every strobe cycle, last one wins
	always @(posedge clk_sys) begin
		junk <= ~junk;
		if (!csN && !wrN) begin
			// an undriven data bus stores whatever floats there
			regs[regSel] <= wrDataOe ? wrData : junk;
		end
	end
	// data only while selected for read
	assign rdData = (!csN && !rdN) ? regs[regSel] : junk;
	// local transfer burst holds the bus, frame work runs on its own
	assign busReq = holdBus;
endmodule : echp_ctrl_model

// *** dv/tb_top.sv ***
/*
  self-checking bench for the card host port decode
  assumes the design package and header are compiled first
*/
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst, hostCycle, hostModule, hostWrite, hostReady, cardIrqN;
	logic [13:2] hostAddr;
	logic [15:0] hostWrData, hostRdData, dmaInData, dmaOutData, rd, exp16;
	logic [18:0] promAddr;
	logic [3:0] ctrlRegSelect;
	logic ctrlCsN, ctrlRdN, ctrlWrN, ctrlBusReq, ctrlBusAck, ctrlIrq, ctrlResetN, holdBus;
	logic sramTestSel, ctrlDataOe, portLatched, sramSeen;
	logic [7:0] ctrlDataIn, ctrlDataOut, regExp [16];
	logic dmaInValid, dmaInReady, dmaOutValid, dmaOutReady;
	logic [31:0] seed;
	logic [15:0] q [8];
	int n_fail, n_compared, cyc, lat, k;
	// prom contents stand-in
	function automatic logic [7:0] promByte(input logic [18:0] a);
		return a[7:0] ^ a[15:8] ^ {5'h00, a[18:16]};
	endfunction : promByte
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	logic [7:0] promData;
	assign promData = promByte(promAddr);
	echp_host_port dut (.clk_sys(clk_sys), .rst(rst), .hostCycle(hostCycle), .hostModule(hostModule),
		.hostWrite(hostWrite), .hostAddr(hostAddr), .hostWrData(hostWrData), .hostReady(hostReady),
		.hostRdData(hostRdData), .cardIrqN(cardIrqN), .promAddr(promAddr), .promData(promData),
		.sramTestSel(sramTestSel), .ctrlRegSelect(ctrlRegSelect), .ctrlCsN(ctrlCsN), .ctrlRdN(ctrlRdN),
		.ctrlWrN(ctrlWrN), .ctrlDataIn(ctrlDataIn), .ctrlDataOut(ctrlDataOut), .ctrlDataOe(ctrlDataOe),
		.ctrlBusReq(ctrlBusReq), .ctrlBusAck(ctrlBusAck), .ctrlIrq(ctrlIrq), .ctrlResetN(ctrlResetN),
		.portLatched(portLatched), .dmaInValid(dmaInValid), .dmaInData(dmaInData), .dmaInReady(dmaInReady),
		.dmaOutValid(dmaOutValid), .dmaOutData(dmaOutData), .dmaOutReady(dmaOutReady));
	echp_ctrl_model ctl (.clk_sys(clk_sys), .csN(ctrlCsN), .rdN(ctrlRdN), .wrN(ctrlWrN),
		.regSel(ctrlRegSelect), .wrData(ctrlDataOut), .rdData(ctrlDataIn), .holdBus(holdBus),
		.busReq(ctrlBusReq), .busAck(ctrlBusAck), .wrDataOe(ctrlDataOe));
	// clock generator
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic chk(input string what, input logic [18:0] seen, input logic [18:0] want);
		n_compared++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : chk
	task automatic end_sim();
		if (n_fail == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim
	// one host cycle, entered and left at a falling edge
	task automatic hcyc(input logic m, input logic w, input logic [13:2] a, input logic [15:0] wd);
		hostModule = m;
		hostWrite = w;
		hostAddr = a;
		hostWrData = wd;
		hostCycle = 1'b1;
		lat = 0;
		do begin
			@(negedge clk_sys);
			lat++;
		end while (hostReady !== 1'b1 && lat < 300);
		rd = hostRdData;
		sramSeen = sramTestSel;
		chk("host answer", hostReady, 19'h0_0001);
		hostCycle = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : hcyc
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		{hostCycle, hostModule, hostWrite, ctrlIrq, holdBus, dmaInValid, dmaOutReady} = 7'h00;
		{hostAddr, hostWrData, dmaInData} = 44'h0;
		{n_fail, n_compared, cyc} = 0;
		seed = 32'h1d83_f8da;
		rst = 1'b1;
		repeat (10) @(negedge clk_sys);
		rst = 1'b0;
		chk("page at reset", promAddr[18:10], 19'h0_0000);
		chk("soft reset at reset", ctrlResetN, 19'h0_0000);
		hcyc(0, 1, 12'hc00, 16'h80a5);
		hcyc(0, 0, 12'h012, 16'h0000);
		chk("prom byte", rd, promByte({9'h0a5, 10'h012}));
		chk("answer time", lat, 19'h0_0001);
		chk("sram select idle", sramSeen, 19'h0_0000);
		hcyc(0, 0, 12'h400, 16'h0000);
		chk("sram select", sramSeen, 19'h0_0001);
		chk("sram read", rd, 19'h0_0000);
		ctrlIrq = 1'b1;
		repeat (2) @(negedge clk_sys);
		hcyc(0, 0, 12'h800, 16'h0000);
		chk("status pending", rd, 19'h0_0000);
		chk("irq pin", cardIrqN, 19'h0_0000);
		ctrlIrq = 1'b0;
		repeat (2) @(negedge clk_sys);
		hcyc(0, 0, 12'h800, 16'h0000);
		chk("status quiet", rd, 19'h0_0001);
		hcyc(0, 1, 12'h800, 16'hffff);
		hcyc(0, 0, 12'hc00, 16'h0000);
		chk("page read", rd, 19'h0_0000);
		chk("page after status write", promAddr[18:10], 19'h0_00a5);
		hcyc(0, 1, 12'hc00, 16'h0155);
		repeat (4) @(negedge clk_sys);
		chk("soft reset on", ctrlResetN, 19'h0_0000);
		chk("page kept", promAddr[18:10], 19'h0_0155);
		hcyc(1, 0, 12'hc03, 16'h0000);
		chk("module read in reset", rd, 19'h0_0000);
		hcyc(0, 1, 12'hc00, 16'h80a5);
		for (int i = 0; i < 16; i++) begin
			regExp[i] = 8'(xs());
			holdBus = (i == 5);
			// one release only, owned by the stretched write
			if (i == 5) begin
				fork
					begin
						repeat (12) @(negedge clk_sys);
						chk("transparent mode", portLatched, 19'h0_0000);
						holdBus = 1'b0;
					end
				join_none
			end
			hcyc(1, 1, 12'hc00 | 12'(i), {8'h00, regExp[i]});
			if (i == 5) chk("stretched write", lat > 12, 19'h0_0001);
		end
		for (int i = 15; i >= 0; i--) begin
			hcyc(1, 0, 12'hc00 | 12'(i), 16'h0000);
			chk("controller register", rd[7:0], regExp[i]);
		end
		for (int i = 0; i < 8; i++) begin
			q[i] = 16'(xs());
			hcyc(1, 1, 12'h800, q[i]);
		end
		dmaOutReady = 1'b1;
		for (int i = 0; i < 8; i++) begin
			k = 0;
			while (dmaOutValid !== 1'b1 && k < 50) begin
				@(negedge clk_sys);
				k++;
			end
			chk("port word valid", dmaOutValid, 19'h0_0001);
			chk("port to controller", dmaOutData, q[i]);
			@(negedge clk_sys);
		end
		dmaOutReady = 1'b0;
		hcyc(0, 1, 12'hc00, 16'hc0a5);
		for (int i = 0; i < 8; i++) begin
			q[i] = 16'(xs());
			dmaInData = q[i];
			dmaInValid = 1'b1;
			chk("buffer space", dmaInReady, 19'h0_0001);
			@(negedge clk_sys);
		end
		dmaInValid = 1'b0;
		chk("buffer full", dmaInReady, 19'h0_0000);
		// port write against read direction: answered, buffer untouched
		hcyc(1, 1, 12'h800, 16'h1234);
		chk("wrong direction write", lat, 19'h0_0002);
		for (int i = 0; i < 8; i++) begin
			hcyc(1, 0, 12'h800, 16'h0000);
			chk("controller to port", rd, q[i]);
		end
		exp16 = 16'(xs());
		fork
			begin
				repeat (15) @(negedge clk_sys);
				chk("latched port mode", portLatched, 19'h0_0001);
				dmaInData = exp16;
				dmaInValid = 1'b1;
				@(negedge clk_sys);
				dmaInValid = 1'b0;
			end
		join_none
		hcyc(1, 0, 12'h800, 16'h0000);
		chk("late port word", rd, exp16);
		chk("empty port stretched", lat > 15, 19'h0_0001);
		hcyc(1, 0, 12'h400, 16'h0000);
		chk("unmapped module read", rd, 19'h0_0000);
		end_sim();
	end
endmodule : tb_top
